// ---- frc_top.sv ----
// Purpose: self-rewrite mode control, interrupt deferral/abort, serial ID check, ROM protect
// Assumes: one clock; software keeps the protected write and clock limits
// Notes: the flash array itself is outside; busy time is modelled by counters
//
// Overview of operation
// - EW1: maskable irq waits for erase end
// - EW1: maskable irq waits for program end
// - Non-maskable irq aborts, resets flash, delayed
// - Watchdog keeps counting during flash commands
// - Serial programming uses async mode 3
// - Mode pin is bidirectional serial data
// - Mode pin high at reset: single-chip
// - Compare received ID with stored ID
// - ROM protect blocks parallel port access
// - Ready flag low while busy, high after
// - EW1 entered by select after enable
`timescale 1ns/1ps
module frc_top #(
   parameter int PROG_CYC = frc_pkg::PROG_CYCLES,
   parameter int ERASE_CYC = frc_pkg::ERASE_CYCLES,
   parameter int WDT_CYC = frc_pkg::WDT_CYCLES,
   parameter int BIT_CYC = frc_pkg::SER_BIT_CYCLES,
   parameter int IDB = frc_pkg::ID_BYTES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire frc_pkg::frc_ctl_wr_t ctl_wr,
   input wire frc_pkg::frc_cmd_t cmd,
   input wire logic irq_req,
   input wire logic nmi_ext_req,
   input wire logic wdt_kick,
   input wire logic mode_pin_i,
   input wire logic [IDB*8-1:0] id_stored,
   input wire logic rom_protect,
   input wire logic par_req,
   output logic cpu_rewrite_enable,
   output logic block0_unlock_enable,
   output logic ew_mode_select,
   output logic erase_write_zero_mode,
   output logic erase_write_one_mode,
   output logic flash_ready_flag,
   output logic flash_abort,
   output logic mi_service,
   output logic nmi_service,
   output logic serial_mode,
   output logic id_checked,
   output logic id_match,
   output logic mode_pin_o,
   output logic mode_pin_oe,
   output logic par_grant
);
   import frc_pkg::*;

   if (PROG_CYC < 1 || ERASE_CYC < 1 || WDT_CYC < 2 || BIT_CYC < 4 || BIT_CYC > 65535
       || IDB < 1 || IDB > 15) begin : g_chk
      $error("frc_top: unsupported parameter value");
   end

   localparam int A_FRST = FRST_CYCLES;
   localparam logic [15:0] BIT_M1 = 16'(BIT_CYC - 1);

   // ----------------------------------------
   // Control bits with protected set
   // ----------------------------------------
   logic [2:0] bits_q, bits_d, arm_q, arm_d;
   logic ew0_d, ew1_d;
   logic any_irq;
   assign any_irq = irq_req | nmi_ext_req;

   always_comb begin
      bits_d = bits_q;
      arm_d = any_irq ? 3'h0 : arm_q;
      if (ctl_wr.valid && ctl_wr.sel <= CTL_EWSEL) begin
         if (!ctl_wr.val) begin
            bits_d[ctl_wr.sel] = 1'b0;
            arm_d[ctl_wr.sel] = !any_irq;
         end else if (arm_q[ctl_wr.sel] && !any_irq) begin
            bits_d[ctl_wr.sel] = 1'b1;
         end
      end
      ew1_d = bits_d[CTL_REWRITE] & bits_d[CTL_EWSEL];
      ew0_d = bits_d[CTL_REWRITE] & ~bits_d[CTL_EWSEL];
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bits_q <= 3'h0;
         arm_q <= 3'h0;
         erase_write_zero_mode <= 1'b0;
         erase_write_one_mode <= 1'b0;
      end else begin
         bits_q <= bits_d;
         arm_q <= arm_d;
         erase_write_zero_mode <= ew0_d;
         erase_write_one_mode <= ew1_d;
      end
   end
   assign cpu_rewrite_enable = bits_q[CTL_REWRITE];
   assign block0_unlock_enable = bits_q[CTL_BLOCK0];
   assign ew_mode_select = bits_q[CTL_EWSEL];

   // ----------------------------------------
   // Flash sequencer, interrupts, watchdog
   // ----------------------------------------
   frc_fl_state_t fl_q, fl_d;
   logic [31:0] cnt_q, cnt_d, wdt_q, wdt_d;
   logic erase_q, erase_d, pend_q, pend_d, hold, nmi_take, wdt_irq, cmd_ok;
   logic ready_d, abort_d, mis_d, nmis_d, grant_d;

   always_comb begin
      fl_d = fl_q;
      cnt_d = cnt_q;
      erase_d = erase_q;
      abort_d = 1'b0;
      nmis_d = 1'b0;
      // Watchdog never pauses for flash work
      wdt_irq = (wdt_q == 32'(WDT_CYC - 1));
      wdt_d = (wdt_kick || wdt_irq) ? 32'h0 : wdt_q + 32'h1;
      nmi_take = nmi_ext_req | wdt_irq;
      cmd_ok = cmd.valid && cpu_rewrite_enable && !serial_mode && (!cmd.block0 || block0_unlock_enable);
      case (fl_q)
         ST_READY: begin
            if (nmi_take) begin
               nmis_d = 1'b1;
            end else if (cmd_ok) begin
               fl_d = ST_BUSY;
               erase_d = cmd.erase;
               cnt_d = cmd.erase ? 32'(ERASE_CYC - 1) : 32'(PROG_CYC - 1);
            end
         end
         ST_BUSY: begin
            if (nmi_take) begin
               fl_d = ST_FRST;
               abort_d = 1'b1;
               cnt_d = 32'(FRST_CYCLES - 1);
            end else if (cnt_q == 32'h0) begin
               fl_d = ST_READY;
            end else begin
               cnt_d = cnt_q - 32'h1;
            end
         end
         ST_FRST: begin
            // Abort drops on the same edge as service and ready
            if (cnt_q == 32'h0) begin
               fl_d = ST_READY;
               nmis_d = 1'b1;
            end else begin
               abort_d = 1'b1;
               cnt_d = cnt_q - 32'h1;
            end
         end
         default: begin
            fl_d = ST_READY;
         end
      endcase
      // EW1 defers maskable service to the end of the operation; EW0 does not
      hold = (erase_write_one_mode && fl_q == ST_BUSY) || fl_q == ST_FRST;
      mis_d = pend_q & ~hold;
      pend_d = (pend_q & hold) | irq_req;
      ready_d = (fl_d == ST_READY);
      grant_d = par_req & ~rom_protect;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fl_q <= ST_READY;
         cnt_q <= 32'h0;
         wdt_q <= 32'h0;
         erase_q <= 1'b0;
         pend_q <= 1'b0;
         flash_ready_flag <= RST_READY;
         flash_abort <= 1'b0;
         mi_service <= 1'b0;
         nmi_service <= 1'b0;
         par_grant <= 1'b0;
      end else begin
         fl_q <= fl_d;
         cnt_q <= cnt_d;
         wdt_q <= wdt_d;
         erase_q <= erase_d;
         pend_q <= pend_d;
         flash_ready_flag <= ready_d;
         flash_abort <= abort_d;
         mi_service <= mis_d;
         nmi_service <= nmis_d;
         par_grant <= grant_d;
      end
   end

   // ----------------------------------------
   // Mode strap and single-wire serial ID check
   // ----------------------------------------
   frc_ser_state_t sr_q, sr_d;
   logic ms1_q, ms2_q, smode_d;
   logic [1:0] strap_q, strap_d;
   logic [15:0] bcnt_q, bcnt_d;
   logic [3:0] bidx_q, bidx_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] nb_q, nb_d;
   logic [IDB*8-1:0] idb_q, idb_d;
   logic chk_d, match_d, pin_d, oe_d;

   always_comb begin
      strap_d = (strap_q == 2'h3) ? strap_q : strap_q + 2'h1;
      // Pin caught once, after the synchroniser has filled
      smode_d = (strap_q == 2'h2) ? !ms2_q : serial_mode;
      sr_d = sr_q;
      bcnt_d = bcnt_q;
      bidx_d = bidx_q;
      sh_d = sh_q;
      nb_d = nb_q;
      idb_d = idb_q;
      chk_d = id_checked;
      match_d = id_match;
      case (sr_q)
         SR_IDLE: begin
            if (serial_mode && !ms2_q) begin
               sr_d = SR_RX;
               bcnt_d = 16'(BIT_CYC / 2);
               bidx_d = 4'h0;
            end
         end
         SR_RX: begin
            if (bcnt_q != 16'h0) begin
               bcnt_d = bcnt_q - 16'h1;
            end else begin
               bcnt_d = BIT_M1;
               bidx_d = bidx_q + 4'h1;
               if (bidx_q == 4'h0 && ms2_q) begin
                  sr_d = SR_IDLE;
               end else if (bidx_q != 4'h0 && bidx_q != SER_STOP_IDX) begin
                  sh_d = {ms2_q, sh_q[7:1]};
               end else if (bidx_q == SER_STOP_IDX) begin
                  idb_d = {idb_q[IDB*8-9:0], sh_q};
                  sr_d = SR_IDLE;
                  nb_d = nb_q + 4'h1;
                  if (nb_q == 4'(IDB - 1)) begin
                     match_d = (idb_d == id_stored);
                     chk_d = 1'b1;
                     sh_d = match_d ? SER_ACK_OK : SER_ACK_NG;
                     nb_d = 4'h0;
                     bidx_d = 4'h0;
                     sr_d = SR_TX;
                  end
               end
            end
         end
         SR_TX: begin
            if (bcnt_q != 16'h0) begin
               bcnt_d = bcnt_q - 16'h1;
            end else begin
               bcnt_d = BIT_M1;
               bidx_d = bidx_q + 4'h1;
               if (bidx_q == SER_STOP_IDX) begin
                  sr_d = SR_IDLE;
               end
            end
         end
         default: begin
            sr_d = SR_IDLE;
         end
      endcase
      // Start low, data LSB first, stop high
      oe_d = (sr_d == SR_TX);
      if (!oe_d || bidx_d == SER_STOP_IDX) begin
         pin_d = 1'b1;
      end else if (bidx_d == 4'h0) begin
         pin_d = 1'b0;
      end else begin
         pin_d = sh_d[bidx_d[2:0] - 3'h1];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ms1_q <= 1'b1;
         ms2_q <= 1'b1;
         strap_q <= 2'h0;
         serial_mode <= 1'b0;
         sr_q <= SR_IDLE;
         bcnt_q <= 16'h0;
         bidx_q <= 4'h0;
         sh_q <= 8'h00;
         nb_q <= 4'h0;
         idb_q <= '0;
         id_checked <= 1'b0;
         id_match <= 1'b0;
         mode_pin_o <= RST_PIN_O;
         mode_pin_oe <= 1'b0;
      end else begin
         ms1_q <= mode_pin_i;
         ms2_q <= ms1_q;
         strap_q <= strap_d;
         serial_mode <= smode_d;
         sr_q <= sr_d;
         bcnt_q <= bcnt_d;
         bidx_q <= bidx_d;
         sh_q <= sh_d;
         nb_q <= nb_d;
         idb_q <= idb_d;
         id_checked <= chk_d;
         id_match <= match_d;
         mode_pin_o <= pin_d;
         mode_pin_oe <= oe_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   erase_defer_a: assert property (fl_q == ST_BUSY && erase_q && erase_write_one_mode |=> !mi_service)
      else $error("maskable irq served during EW1 erase");
   prog_defer_a: assert property (fl_q == ST_BUSY && !erase_q && erase_write_one_mode |=> !mi_service)
      else $error("maskable irq served during EW1 program");
   nmi_abort_a: assert property (fl_q == ST_BUSY && nmi_take |=> flash_abort ##[A_FRST:A_FRST] nmi_service)
      else $error("abort or delayed nmi service wrong");
   wdt_runs_a: assert property (fl_q != ST_READY && !wdt_kick |=> wdt_q != $past(wdt_q))
      else $error("watchdog stalled during flash work");
   ser_start_a: assert property ($rose(mode_pin_oe) |-> !mode_pin_o)
      else $error("reply frame lacks start bit");
   pin_drive_a: assert property (mode_pin_oe |-> serial_mode && sr_q == SR_TX)
      else $error("mode pin driven outside serial reply");
   strap_cap_a: assert property (strap_q == 2'h2 |=> serial_mode == !$past(ms2_q))
      else $error("mode strap not captured");
   id_cmp_a: assert property ($rose(sr_q == SR_TX) |-> id_checked && id_match == (idb_q == id_stored))
      else $error("id match result wrong");
   par_block_a: assert property (rom_protect |=> !par_grant)
      else $error("parallel access granted under protect");
   ready_flag_a: assert property (flash_ready_flag == (fl_q == ST_READY))
      else $error("ready flag disagrees with sequencer");
   ew1_entry_a: assert property ($rose(erase_write_one_mode) |-> cpu_rewrite_enable && ew_mode_select)
      else $error("EW1 entered without enable");

   abort_seen_c: cover property (fl_q == ST_BUSY && nmi_take ##1 flash_abort);
   defer_seen_c: cover property (erase_write_one_mode && fl_q == ST_BUSY && pend_q ##[1:20] mi_service);
   id_ok_c: cover property ($rose(id_match));
   erase_done_c: cover property (fl_q == ST_BUSY && erase_q ##1 fl_q == ST_READY);
endmodule : frc_top

// ---- frc_pkg.sv ----
// Purpose: shared constants and types for flash rewrite and interrupt control
// Assumes: core_clk at 250 MHz
// Notes: long counts are re-declared as top-level parameters
package frc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int PROG_TIME_US = 50;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_TIME_MS = 400;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int FRST_TIME_NS = 100;
   localparam int FRST_CYCLES = (FRST_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int WDT_CYCLES = 65536;
   localparam int SER_BAUD = 38400;
   localparam int SER_BIT_CYCLES = (CLK_MHZ * 1000000) / SER_BAUD;
   localparam int ID_BYTES = 7;
   // ----------------------------------------
   // Encodings and reset values
   // ----------------------------------------
   localparam logic [1:0] CTL_REWRITE = 2'h0;
   localparam logic [1:0] CTL_BLOCK0 = 2'h1;
   localparam logic [1:0] CTL_EWSEL = 2'h2;
   localparam logic [7:0] SER_ACK_OK = 8'hB0;
   localparam logic [7:0] SER_ACK_NG = 8'h80;
   localparam logic [3:0] SER_STOP_IDX = 4'h9;
   localparam logic RST_READY = 1'b1;
   localparam logic RST_PIN_O = 1'b1;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic [1:0] sel;
      logic val;
   } frc_ctl_wr_t;
   typedef struct packed {
      logic valid;
      logic erase;
      logic block0;
   } frc_cmd_t;
   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_BUSY = 2'b01,
      ST_FRST = 2'b11
   } frc_fl_state_t;
   typedef enum logic [1:0] {
      SR_IDLE = 2'b00,
      SR_RX = 2'b01,
      SR_TX = 2'b11
   } frc_ser_state_t;
endpackage : frc_pkg

// ---- frc_prog_model.sv ----
// Purpose: serial programmer model on the mode pin
// Assumes: line idles high, device output wins while enabled
// Notes: frames are start, 8 data LSB first, stop
`timescale 1ns/1ps
module frc_prog_model #(
   parameter int BIT_CYC = 8,
   parameter int IDB = 7
) (
   input wire logic core_clk,
   input wire logic line,
   output logic prog_o
);
   initial prog_o = 1'b1;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic drive(input logic v);
      prog_o = v;
   endtask : drive
   // Full-length bits; programmer owns the line between replies
   task automatic put_bit(input logic b);
      prog_o = b;
      tick(BIT_CYC);
   endtask : put_bit
   task automatic send_id(input logic [IDB*8-1:0] id, output logic [7:0] ack, output logic ok);
      int n;
      ack = 8'h00;
      n = 0;
      for (int k = IDB - 1; k >= 0; k--) begin
         put_bit(1'b0);
         for (int i = 0; i < 8; i++) put_bit(id[k*8+i]);
         if (k > 0) put_bit(1'b1);
      end
      // Last stop bit left high: the reply may start mid-bit
      prog_o = 1'b1;
      while (line !== 1'b0 && n < 4 * BIT_CYC) begin
         tick(1);
         n++;
      end
      tick(BIT_CYC / 2);
      ok = (line === 1'b0) && (n < 4 * BIT_CYC);
      for (int i = 0; i < 8; i++) begin
         tick(BIT_CYC);
         ack[i] = line;
      end
      tick(BIT_CYC);
      ok = ok && (line === 1'b1);
   endtask : send_id
endmodule : frc_prog_model

// ---- tb_top.sv ----
// Purpose: self-checking bench for flash rewrite and interrupt control
// Assumes: shortened counts; erase outlasts the watchdog period
// Notes: background kicker keeps the watchdog quiet unless disabled
`timescale 1ns/1ps
module tb_top;
   import frc_pkg::*;
   localparam int PC = 5;
   localparam int EC = 300;
   localparam int BC = 8;
   localparam logic [55:0] ID_OK = 56'h0123456789ABCD;
   logic core_clk, rst, irq_req, nmi_ext_req, wdt_kick, rom_protect, par_req, kick_en;
   logic rwe, b0e, sel_q, ew0, ew1, ready, abort, mi, nmi, ser, idc, idm, pin_o, pin_oe, grant;
   logic prog_o, mode_line;
   frc_ctl_wr_t ctl_wr;
   frc_cmd_t cmd;
   int bad_count = 0;
   int comparisons = 0;
   assign mode_line = pin_oe ? pin_o : prog_o;
   frc_top #(.PROG_CYC(PC), .ERASE_CYC(EC), .WDT_CYC(200), .BIT_CYC(BC)) dut_u (.core_clk(core_clk), .rst(rst),
      .ctl_wr(ctl_wr), .cmd(cmd), .irq_req(irq_req), .nmi_ext_req(nmi_ext_req), .wdt_kick(wdt_kick),
      .mode_pin_i(mode_line), .id_stored(ID_OK), .rom_protect(rom_protect), .par_req(par_req),
      .cpu_rewrite_enable(rwe), .block0_unlock_enable(b0e), .ew_mode_select(sel_q), .erase_write_zero_mode(ew0),
      .erase_write_one_mode(ew1), .flash_ready_flag(ready), .flash_abort(abort), .mi_service(mi),
      .nmi_service(nmi), .serial_mode(ser), .id_checked(idc), .id_match(idm), .mode_pin_o(pin_o),
      .mode_pin_oe(pin_oe), .par_grant(grant));
   frc_prog_model #(.BIT_CYC(BC), .IDB(7)) prog_u (.core_clk(core_clk), .line(mode_line), .prog_o(prog_o));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask : step
   task automatic wr_ctl(input logic [1:0] sel, input logic v);
      ctl_wr = '{valid: 1'b1, sel: sel, val: v};
      step();
   endtask : wr_ctl
   task automatic idle(input int n);
      ctl_wr = '0;
      repeat (n) step();
   endtask : idle
   task automatic do_reset();
      rst = 1'b1;
      repeat (3) step();
      rst = 1'b0;
      repeat (6) step();
   endtask : do_reset
   task automatic finish_test();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // Command with a maskable request in the same cycle
   task automatic run_op(input logic er, input logic b0, input logic hold, input int len);
      int n;
      logic mi_busy;
      logic mi_late;
      n = 0;
      mi_busy = 1'b0;
      mi_late = 1'b0;
      cmd = '{valid: 1'b1, erase: er, block0: b0};
      irq_req = 1'b1;
      step();
      cmd = '0;
      irq_req = 1'b0;
      while (ready !== 1'b1 && n < 400) begin
         mi_busy |= (mi === 1'b1);
         step();
         n++;
      end
      repeat (4) begin
         mi_late |= (mi === 1'b1);
         step();
      end
      chk(n, len);
      chk(mi_busy, (len > 0) && !hold);
      chk(mi_late, hold || len == 0);
   endtask : run_op
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_ctl();
      wr_ctl(CTL_REWRITE, 1'b1);
      idle(1);
      chk(rwe, 1'b0);
      wr_ctl(CTL_REWRITE, 1'b0);
      ctl_wr = '0;
      irq_req = 1'b1;
      step();
      irq_req = 1'b0;
      wr_ctl(CTL_REWRITE, 1'b1);
      idle(1);
      chk(rwe, 1'b0);
      wr_ctl(CTL_REWRITE, 1'b0);
      wr_ctl(CTL_REWRITE, 1'b1);
      idle(1);
      chk({rwe, ew0}, 2'b11);
      wr_ctl(CTL_EWSEL, 1'b0);
      wr_ctl(CTL_EWSEL, 1'b1);
      idle(1);
      chk({sel_q, ew1, ew0}, 3'b110);
   endtask : t_ctl
   task automatic t_ew1();
      run_op(1'b0, 1'b0, 1'b1, PC);
      run_op(1'b1, 1'b1, 1'b1, 0);
      wr_ctl(CTL_BLOCK0, 1'b0);
      wr_ctl(CTL_BLOCK0, 1'b1);
      idle(1);
      run_op(1'b1, 1'b1, 1'b1, EC);
   endtask : t_ew1
   task automatic t_nmi();
      int n;
      n = 0;
      cmd = '{valid: 1'b1, erase: 1'b1, block0: 1'b0};
      step();
      cmd = '0;
      nmi_ext_req = 1'b1;
      step();
      nmi_ext_req = 1'b0;
      while (abort === 1'b1 && n < 100) begin
         step();
         n++;
      end
      chk(n, FRST_CYCLES);
      chk({nmi, ready}, 2'b11);
      step();
      run_op(1'b1, 1'b0, 1'b1, EC);
   endtask : t_nmi
   // Erase outlasts the watchdog, so an unkicked count must abort it
   task automatic t_wdt();
      int n;
      logic saw;
      n = 0;
      saw = 1'b0;
      kick_en = 1'b0;
      cmd = '{valid: 1'b1, erase: 1'b1, block0: 1'b0};
      step();
      cmd = '0;
      while (ready !== 1'b1 && n < 400) begin
         saw |= (abort === 1'b1);
         step();
         n++;
      end
      chk({saw, nmi}, 2'b11);
      kick_en = 1'b1;
      idle(60);
   endtask : t_wdt
   task automatic t_ew0();
      // Bench clock stands for a core already slowed by software
      wr_ctl(CTL_EWSEL, 1'b0);
      idle(1);
      chk(ew0, 1'b1);
      run_op(1'b0, 1'b0, 1'b0, PC);
   endtask : t_ew0
   task automatic t_par();
      par_req = 1'b1;
      rom_protect = 1'b1;
      repeat (2) step();
      chk(grant, 1'b0);
      rom_protect = 1'b0;
      repeat (2) step();
      chk(grant, 1'b1);
      par_req = 1'b0;
   endtask : t_par
   task automatic t_serial();
      logic [7:0] ack;
      logic ok;
      prog_u.drive(1'b0);
      do_reset();
      chk(ser, 1'b1);
      prog_u.drive(1'b1);
      repeat (4 * BC) step();
      prog_u.send_id(ID_OK, ack, ok);
      repeat (4) step();
      chk({ok, ack, idc, idm, pin_oe}, {1'b1, SER_ACK_OK, 3'b110});
      repeat (4 * BC) step();
      prog_u.send_id(ID_OK ^ 56'h1, ack, ok);
      chk({ok, ack, idm}, {1'b1, SER_ACK_NG, 1'b0});
      do_reset();
      chk(ser, 1'b0);
   endtask : t_serial
   // ----------------------------------------
   // Clock, kicker, watchdog, main
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      wdt_kick = 1'b0;
      forever begin
         repeat (50) step();
         wdt_kick = kick_en;
         step();
         wdt_kick = 1'b0;
      end
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      finish_test();
   end
   initial begin
      {irq_req, nmi_ext_req, rom_protect, par_req} = 4'h0;
      ctl_wr = '0;
      cmd = '0;
      kick_en = 1'b1;
      do_reset();
      t_ctl();
      t_ew1();
      t_nmi();
      t_wdt();
      t_ew0();
      t_par();
      t_serial();
      finish_test();
   end
endmodule : tb_top
